/* verilog/fsm_fault_status.sv */
// Fault and warning supervision with status LED and fault output
module fsm_fault_status
  import fsm_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC
)
(
  // Clock and reset
  input  wire logic I_REF_CLK,
  input  wire logic I_RST,
  // Fault detector levels (pins)
  input  wire logic I_SUPPLY_LOW,
  input  wire logic I_STEP_LOSS,
  input  wire logic I_OVER_TEMP,
  input  wire logic I_OVER_CURRENT,
  input  wire logic I_REF_NOT_FOUND,
  input  wire logic [ERR_NUM-1:0] I_CRITICAL_MASK,
  // Operation and warning sources (pins)
  input  wire logic I_AUTO_MODE,
  input  wire logic I_UNCONFIGURED,
  input  wire logic I_ACTUATOR_CHANGED,
  input  wire logic I_REF_RUN_DONE,
  input  wire logic I_CONFIG_LOADED,
  // Acknowledge sources (pins)
  input  wire logic I_TOOL_ACK,
  input  wire logic I_BTN_OPEN,
  input  wire logic I_BTN_CLOSE,
  input  wire logic I_EXT_RESET,
  // Outputs
  output logic      O_LED_RED,
  output logic      O_LED_GREEN,
  output logic      O_FAULT_OUTPUT,
  output logic      O_FAULT_LED,
  output logic [ERR_NUM-1:0] O_ERRORS,
  output logic      O_WARNING
);
  // Positions of each pin in the synchroniser vector
  // Event and mode levels
  localparam int SYN_EXT  = 0;
  localparam int SYN_TOOL = 1;
  localparam int SYN_CFG  = 2;
  localparam int SYN_RUN  = 3;
  localparam int SYN_ACT  = 4;
  localparam int SYN_UNCF = 5;
  localparam int SYN_AUTO = 6;
  // Detector levels in error bit order, then their critical flags
  localparam int SYN_DET  = 7;
  localparam int SYN_CRIT = SYN_DET + ERR_NUM;
  localparam int NIN      = SYN_CRIT + ERR_NUM;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] syn;
  logic [NIN-1:0] syn_d;

  // Pins packed in the order of the positions above
  assign raw = {I_CRITICAL_MASK, I_REF_NOT_FOUND, I_OVER_CURRENT, I_OVER_TEMP, I_STEP_LOSS,
                I_SUPPLY_LOW, I_AUTO_MODE, I_UNCONFIGURED, I_ACTUATOR_CHANGED,
                I_REF_RUN_DONE, I_CONFIG_LOADED, I_TOOL_ACK, I_EXT_RESET};

  // One synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      fsm_sync u_sync (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RST),
        .i_pin   (raw[g]),
        .o_level (syn[g])
      );
    end
  endgenerate

  // Front buttons kept apart, so that their overlap can be judged
  logic btn_open;
  logic btn_close;
  fsm_sync u_open  (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_pin(I_BTN_OPEN),  .o_level(btn_open));
  fsm_sync u_close (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_pin(I_BTN_CLOSE), .o_level(btn_close));

  // Decoded clean levels
  logic [ERR_NUM-1:0] crit_mask;
  logic [ERR_NUM-1:0] det;
  logic auto_mode;
  logic unconf;
  logic both_btn;
  logic both_btn_d;
  assign crit_mask = syn[SYN_CRIT +: ERR_NUM];
  assign det       = syn[SYN_DET +: ERR_NUM];
  assign auto_mode = syn[SYN_AUTO];
  assign unconf    = syn[SYN_UNCF];
  assign both_btn  = btn_open & btn_close;

  // Rising edges of event inputs; edge flops reset low like the idle pins, so no false edge
  logic act_rise;
  logic refrun_rise;
  logic cfg_rise;
  logic tool_rise;
  logic ext_rise;
  assign act_rise    = syn[SYN_ACT] & ~syn_d[SYN_ACT];
  assign refrun_rise = syn[SYN_RUN] & ~syn_d[SYN_RUN];
  assign cfg_rise    = syn[SYN_CFG] & ~syn_d[SYN_CFG];
  assign tool_rise   = syn[SYN_TOOL] & ~syn_d[SYN_TOOL];
  assign ext_rise    = syn[SYN_EXT] & ~syn_d[SYN_EXT];

  // Acknowledge decode; external reset only counts in automatic mode
  logic btn_ack;
  logic ext_ack;
  logic ack;
  assign btn_ack = both_btn & ~both_btn_d;
  assign ext_ack = ext_rise & auto_mode;
  assign ack     = tool_rise | btn_ack | ext_ack;

  // Error, critical latch and warning state
  logic [ERR_NUM-1:0] err;
  logic [ERR_NUM-1:0] crit;
  logic [ERR_NUM-1:0] next_err;
  logic [ERR_NUM-1:0] next_crit;
  logic warn_evt;
  logic next_warn_evt;

  // Tool acknowledge of a non-critical heat or current error leaves a warning
  logic tool_warn;
  assign tool_warn = tool_rise && (err[ERR_TEMP] || err[ERR_CURR]) && !crit[ERR_TEMP] && !crit[ERR_CURR];

  // Next error, critical and warning state
  always_comb begin
    next_err      = err;
    next_crit     = crit | (det & crit_mask);
    next_warn_evt = warn_evt;
    // Clear first, so that a warning source in the same cycle wins
    if (refrun_rise || cfg_rise) begin
      next_warn_evt = 1'b0;
    end
    if (ack) begin
      next_err = crit;
    end
    if (tool_warn || act_rise) begin
      next_warn_evt = 1'b1;
    end
    // Detection set wins over acknowledge clear
    next_err = next_err | det | next_crit;
  end

  // Warning is pending while unconfigured or a latched warning event exists
  logic warn;
  assign warn = warn_evt | unconf;

  // Colour selection
  fsm_colour_e colour;
  always_comb begin
    if (|err) begin
      colour = FSM_RED;
    end else if (warn) begin
      colour = FSM_ORANGE;
    end else begin
      colour = FSM_GREEN;
    end
  end

  // Blink divider; a one-cycle tick marks each half flash period
  logic [BLINK_W-1:0] blink_cnt;
  logic [BLINK_W-1:0] next_blink_cnt;
  logic blink_tick;
  logic phase;
  logic next_phase;
  always_comb begin
    blink_tick     = (blink_cnt >= BLINK_W'(BLINK_CYCLES - 1));
    next_blink_cnt = blink_cnt + BLINK_W'(1);
    if (blink_tick) begin
      next_blink_cnt = '0;
    end
  end

  // Flash phase flips on each tick
  always_comb begin
    next_phase = phase;
    if (blink_tick) begin
      next_phase = ~phase;
    end
  end

  // Output next values; orange is red and green lit together
  logic next_red;
  logic next_green;
  logic next_fault;
  always_comb begin
    next_red   = phase && (colour != FSM_GREEN);
    next_green = phase && (colour != FSM_RED);
    next_fault = auto_mode && (|err);
  end

  // State and output registers
  // Error and warning outputs carry the same one-cycle lag as the LEDs, so all move together
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      syn_d          <= '0;
      both_btn_d     <= 1'b0;
      err            <= '0;
      crit           <= '0;
      warn_evt       <= 1'b0;
      blink_cnt      <= '0;
      phase          <= 1'b0;
      O_LED_RED      <= 1'b0;
      O_LED_GREEN    <= 1'b0;
      O_FAULT_OUTPUT <= 1'b0;
      O_FAULT_LED    <= 1'b0;
      O_ERRORS       <= '0;
      O_WARNING      <= 1'b0;
    end else begin
      syn_d          <= syn;
      both_btn_d     <= both_btn;
      err            <= next_err;
      crit           <= next_crit;
      warn_evt       <= next_warn_evt;
      blink_cnt      <= next_blink_cnt;
      phase          <= next_phase;
      O_LED_RED      <= next_red;
      O_LED_GREEN    <= next_green;
      O_FAULT_OUTPUT <= next_fault;
      O_FAULT_LED    <= next_fault;
      O_ERRORS       <= err;
      O_WARNING      <= warn;
    end
  end
endmodule

/* verilog/fsm_pkg.sv */
// Package of constants and types for the fault and status manager
package fsm_pkg;
  // Error bit positions
  localparam int ERR_LOWV  = 0;
  localparam int ERR_STEP  = 1;
  localparam int ERR_TEMP  = 2;
  localparam int ERR_CURR  = 3;
  localparam int ERR_REF   = 4;
  localparam int ERR_NUM   = 5;
  // Blink timing: half period of the status flash
  localparam int BLINK_HALF_MS = 250;
  localparam int CLK_KHZ       = 10_000;
  localparam int BLINK_CYC     = BLINK_HALF_MS * CLK_KHZ;
  localparam int BLINK_W       = 22;
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYC - 1);
  // Status colour
  typedef enum logic [1:0] {FSM_GREEN, FSM_ORANGE, FSM_RED} fsm_colour_e;
endpackage

/* verilog/fsm_sync.sv */
// Three-flop input synchroniser with second/third agreement
module fsm_sync
  import fsm_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Pin in, clean level out
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // Level changes only once the two later stages agree
  always_comb begin
    next_level = o_level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  // Stage registers; s1 is read by s2 alone
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1      <= i_pin;
      s2      <= s1;
      s3      <= s2;
      o_level <= next_level;
    end
  end
endmodule

/* testbench/fsm_sva.sv */
// Port checker for the fault and status manager
module fsm_sva
  import fsm_pkg::*;
(
  // Clock and reset
  input wire logic               I_REF_CLK,
  input wire logic               I_RST,
  // Detector, mode and warning pins
  input wire logic               I_SUPPLY_LOW,
  input wire logic               I_STEP_LOSS,
  input wire logic               I_OVER_TEMP,
  input wire logic               I_OVER_CURRENT,
  input wire logic               I_REF_NOT_FOUND,
  input wire logic               I_AUTO_MODE,
  input wire logic               I_ACTUATOR_CHANGED,
  input wire logic               I_REF_RUN_DONE,
  input wire logic               I_CONFIG_LOADED,
  input wire logic [ERR_NUM-1:0] I_CRITICAL_MASK,
  // Block outputs
  input wire logic               O_LED_RED,
  input wire logic               O_LED_GREEN,
  input wire logic               O_FAULT_OUTPUT,
  input wire logic               O_FAULT_LED,
  input wire logic               O_WARNING,
  input wire logic [ERR_NUM-1:0] O_ERRORS
);
  logic [ERR_NUM-1:0] det;
  logic [3:0]         age;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  // Detector pins in error bit order
  assign det = {I_REF_NOT_FOUND, I_OVER_CURRENT, I_OVER_TEMP, I_STEP_LOSS, I_SUPPLY_LOW};
  // Cycles since a warning clear; saturates so long idle never wraps
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) age <= 4'hf;
    else if (I_REF_RUN_DONE || I_CONFIG_LOADED) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  end
  for (genvar k = 0; k < ERR_NUM; k++) begin : g_det
    err_set_a: assert property (
      det[k] [*8] |-> ##[0:2] O_ERRORS[k]) else $error("error not latched");
  end
  red_err_a: assert property (
    |O_ERRORS && $past(|O_ERRORS) |-> !O_LED_GREEN) else $error("green with error");
  green_ok_a: assert property (
    O_ERRORS == '0 && !O_WARNING && $past(O_ERRORS == '0 && !O_WARNING) |-> !O_LED_RED)
    else $error("red while healthy");
  orange_lit_a: assert property (
    O_ERRORS == '0 && O_WARNING && $past(O_ERRORS == '0 && O_WARNING) |-> O_LED_RED == O_LED_GREEN)
    else $error("warning colour");
  fault_pair_a: assert property (
    O_FAULT_OUTPUT == O_FAULT_LED) else $error("fault LED differs");
  fault_auto_a: assert property (
    I_AUTO_MODE [*8] ##0 (|O_ERRORS) |-> O_FAULT_OUTPUT) else $error("no fault output in automatic mode");
  fault_idle_a: assert property (
    !(|O_ERRORS) |-> !O_FAULT_OUTPUT) else $error("fault output without error");
  fault_manual_a: assert property (
    (!I_AUTO_MODE) [*8] |-> !O_FAULT_OUTPUT) else $error("fault output in manual mode");
  crit_hold_a: assert property (
    |(O_ERRORS & I_CRITICAL_MASK) |=> (O_ERRORS & $past(O_ERRORS & I_CRITICAL_MASK))
    == $past(O_ERRORS & I_CRITICAL_MASK)) else $error("critical error cleared");
  warn_clr_a: assert property (
    $fell(O_WARNING) |-> age < 4'hc) else $error("warning dropped alone");
  warn_set_a: assert property (
    $rose(I_ACTUATOR_CHANGED) |-> ##[4:10] O_WARNING) else $error("no warning");
endmodule
bind fsm_fault_status fsm_sva u_sva (.*);

/* testbench/fsm_pnr.sv */
// Model of master control, front buttons and tool acknowledge
module fsm_pnr (
  // Clock and request from the bench
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [1:0] i_cmd,
  // Acknowledge sources seen by the block
  output logic            o_tool_ack,
  output logic            o_btn_open,
  output logic            o_btn_close,
  output logic            o_ext_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  // A request stands six cycles, longer than the input synchroniser
  always @(negedge i_clk) begin
    if (i_go && cnt == 3'h0) cnt <= 3'h6;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
  end
  // Only the chosen source moves; the rest idle low
  assign o_tool_ack  = cnt != 3'h0 && i_cmd == 2'h0;
  assign o_btn_open  = cnt != 3'h0 && i_cmd == 2'h1;
  assign o_btn_close = cnt > 3'h2 && i_cmd == 2'h1;
  assign o_ext_reset = cnt != 3'h0 && i_cmd == 2'h2;
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the fault and status manager
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_REF_CLK = 1'b0, I_RST = 1'b1, I_AUTO_MODE = 1'b1, I_UNCONFIGURED = 1'b0, go = 1'b0;
  logic [4:0] det = 5'h00, I_CRITICAL_MASK = 5'h00, O_ERRORS;
  logic [2:0] ev = 3'h0;
  logic [1:0] cmd = 2'h0;
  logic O_LED_RED, O_LED_GREEN, O_FAULT_OUTPUT, O_FAULT_LED, O_WARNING;
  logic I_TOOL_ACK, I_BTN_OPEN, I_BTN_CLOSE, I_EXT_RESET;
  int n_errors = 0;
  int n_tests = 0;
  initial forever #50 I_REF_CLK = ~I_REF_CLK;
  fsm_pnr u_pnr (.i_clk(I_REF_CLK), .i_go(go), .i_cmd(cmd), .o_tool_ack(I_TOOL_ACK),
    .o_btn_open(I_BTN_OPEN), .o_btn_close(I_BTN_CLOSE), .o_ext_reset(I_EXT_RESET));
  // Short blink keeps colour checks brief
  fsm_fault_status #(.BLINK_CYCLES(4)) uut (.*, .I_SUPPLY_LOW(det[0]), .I_STEP_LOSS(det[1]),
    .I_OVER_TEMP(det[2]), .I_OVER_CURRENT(det[3]), .I_REF_NOT_FOUND(det[4]),
    .I_ACTUATOR_CHANGED(ev[0]), .I_REF_RUN_DONE(ev[1]), .I_CONFIG_LOADED(ev[2]));
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge I_REF_CLK);
  endtask
  // Colours seen over three blink phases, as red and green
  task automatic seen(output logic [7:0] c);
    c = 8'h00;
    repeat (12) begin
      @(negedge I_REF_CLK);
      c = c | {6'h00, O_LED_RED, O_LED_GREEN};
    end
  endtask
  task automatic ack(input logic [1:0] k);
    cmd <= k;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(16);
  endtask
  task automatic evp(input int b);
    ev[b] <= 1'b1;
    cyc(6);
    ev[b] <= 1'b0;
    cyc(12);
  endtask
  task automatic t_warn;
    logic [7:0] c;
    seen(c);
    chk(c, 8'h01);
    evp(0);
    seen(c);
    chk(c | {7'h0, O_WARNING} << 2, 8'h07);
    evp(2);
    chk(8'(O_WARNING), 8'h00);
    I_UNCONFIGURED <= 1'b1;
    cyc(10);
    chk(8'(O_WARNING), 8'h01);
    I_UNCONFIGURED <= 1'b0;
    evp(2);
    chk(8'(O_WARNING), 8'h00);
  endtask
  // Each error in turn, cleared by tool, buttons or external reset
  task automatic t_errors;
    logic [7:0] c;
    for (int i = 0; i < 5; i++) begin
      det[i] <= 1'b1;
      cyc(10);
      chk({1'b0, O_FAULT_OUTPUT, O_FAULT_LED, O_ERRORS}, 8'h60 | 8'(1 << i));
      seen(c);
      chk(c, 8'h02);
      det[i] <= 1'b0;
      ack(2'(i % 3));
      chk({1'b0, O_WARNING, O_FAULT_OUTPUT, O_ERRORS}, {1'b0, 1'(i == 3), 6'h00});
      seen(c);
      chk(c, (i == 3) ? 8'h03 : 8'h01);
      evp(1);
      chk(8'(O_WARNING), 8'h00);
    end
  endtask
  task automatic t_manual;
    I_AUTO_MODE <= 1'b0;
    det[1] <= 1'b1;
    cyc(10);
    det[1] <= 1'b0;
    chk({2'h0, O_FAULT_OUTPUT, O_ERRORS}, 8'h02);
    ack(2'h2);
    chk(8'(O_ERRORS), 8'h02);
    ack(2'h1);
    chk(8'(O_ERRORS), 8'h00);
    det[1] <= 1'b1;
    cyc(10);
    det[1] <= 1'b0;
    ack(2'h0);
    chk({2'h0, O_WARNING, O_ERRORS}, 8'h00);
    I_AUTO_MODE <= 1'b1;
  endtask
  // Critical error survives acks, then a mid-run reset clears it
  task automatic t_crit;
    I_CRITICAL_MASK <= 5'h04;
    det[2] <= 1'b1;
    cyc(10);
    det[2] <= 1'b0;
    ack(2'h0);
    ack(2'h1);
    ack(2'h2);
    chk({1'b0, O_FAULT_OUTPUT, O_WARNING, O_ERRORS}, 8'h44);
    I_RST <= 1'b1;
    cyc(3);
    I_RST <= 1'b0;
    I_CRITICAL_MASK <= 5'h00;
    cyc(10);
    chk(8'(O_ERRORS), 8'h00);
  endtask
  task automatic conclude;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(6);
    I_RST <= 1'b0;
    cyc(4);
    t_warn;
    t_errors;
    t_manual;
    t_crit;
    conclude;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge I_REF_CLK);
    n_errors++;
    conclude;
  end
endmodule
